// ==== rtl/mrfs_pkg.sv ====
// Package: register map, field layout and carriers of the receive filter/status block
package mrfs_pkg;

    // --------------------------------------------------------------
    // Register byte addresses
    // --------------------------------------------------------------
    localparam logic [7:0] OFS_RX_CFG      = 8'h0c;
    localparam logic [7:0] OFS_STATION0    = 8'h20;
    localparam logic [7:0] OFS_STATION5    = 8'h34;
    localparam logic [7:0] OFS_TX_PAGE     = 8'h40;
    localparam logic [7:0] OFS_TX_LEN_LO   = 8'h44;
    localparam logic [7:0] OFS_TX_LEN_HI   = 8'h48;
    localparam logic [7:0] OFS_RING_FIRST  = 8'h4c;
    localparam logic [7:0] OFS_RING_LAST   = 8'h50;
    localparam logic [7:0] OFS_RING_BOUND  = 8'h54;
    localparam logic [7:0] OFS_RING_CUR    = 8'h58;
    localparam logic [7:0] OFS_ALIGN_TALLY = 8'h60;
    localparam logic [7:0] OFS_CRC_TALLY   = 8'h64;
    localparam logic [7:0] OFS_MISS_TALLY  = 8'h68;

    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int CFG_SAVE_ERR  = 0;   // save_errored_packets
    localparam int CFG_SHORT     = 1;   // accept_short_frames
    localparam int CFG_ALL_ONES  = 2;   // accept_all_ones_dest
    localparam int CFG_GROUP     = 3;   // accept_group_dest
    localparam int CFG_ANY_PHYS  = 4;   // accept_any_physical
    localparam int CFG_MONITOR   = 5;   // monitor_only
    localparam int CFG_WIDTH     = 6;
    localparam int ST_INTACT     = 0;
    localparam int ST_CRC        = 1;
    localparam int ST_ALIGN      = 2;
    localparam int ST_FIFO_OVF   = 3;
    localparam int ST_MISSED     = 4;
    localparam int ST_ADDR_TYPE  = 5;
    localparam int ST_RX_DIS     = 6;
    localparam int ST_DEFER      = 7;
    localparam int GROUP_BIT     = 40;  // first bit on the wire of the first byte

    // --------------------------------------------------------------
    // Reset values and limits
    // --------------------------------------------------------------
    localparam logic [7:0]  CFG_RESET     = 8'h00;
    localparam logic [7:0]  TALLY_MAX     = 8'hff;
    localparam logic [15:0] MIN_FRAME_LEN = 16'h0040;  // 64 bytes
    localparam logic [15:0] MIN_RUNT_LEN  = 16'h0008;  // 8 bytes
    localparam logic [47:0] ALL_ONES_DEST = 48'hffff_ffff_ffff;
    localparam logic [7:0]  PAGE_LOW_ZERO = 8'h00;

    // --------------------------------------------------------------
    // Carriers
    // --------------------------------------------------------------
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } mrfs_apb_req_s;

    typedef struct packed {
        logic [47:0] dest_addr;    // First received byte in [47:40]
        logic [15:0] byte_count;
        logic        crc_ok;       // CRC matched at last byte boundary
        logic [2:0]  dribble_bits; // Bits past the last byte boundary
        logic        hash_hit;     // Group address passed the hashing array
    } mrfs_frame_s;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'b001,
        RX_FRAME = 3'b010,
        RX_DROP  = 3'b100
    } mrfs_rx_e;

endpackage : mrfs_pkg

// ==== rtl/mrfs_core.sv ====
// Receive address filter, receive status and buffer ring pointers behind an APB port
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
// What this block does
// - Errored packets kept only when save bit set
// - Runts accepted only with bit, at least 8
// - All-ones destination accepted only with broadcast bit
// - Group destinations other than all-ones accepted only when hash passes
// - Physical must match station unless promiscuous
// - Monitor mode checks but never buffers, counts missed
// - Broadcast and multicast acceptance are OR'd
// - Status written at head when packet kept
// - Status cleared when next packet arrives
// - Intact bit only when all error bits clear
// - CRC error sets bit, counts tally one
// - Alignment error sets bit, counts tally zero
// - Alignment error never without CRC error
// - FIFO overflow sets bit and aborts packet
// - Missed packet sets bit, counts tally two
// - Address type zero physical, one group
// - Receiver disabled bit follows monitor mode
// - Deferring bit follows carrier sense or collision
// - Registers are eight bits, wide ones split
// - Page registers hold address bits 15 to 8
// - Abort local DMA when next page hits boundary
module mrfs_core (
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    input  wire mrfs_pkg::mrfs_apb_req_s apb_req,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  rx_start,
    input  wire logic                  rx_end,
    input  wire mrfs_pkg::mrfs_frame_s rx_frame,
    input  wire logic                  rx_fifo_overflow,
    input  wire logic                  rx_link_req,
    input  wire logic                  carrier_sense,
    input  wire logic                  collision,
    output logic                       rx_abort,
    output logic                       rx_commit,
    output logic                       status_wr,
    output logic [7:0]                 status_byte,
    output logic                       dma_abort,
    output logic [15:0]                rx_dma_addr,
    output logic [15:0]                tx_dma_addr,
    output logic [15:0]                tx_length
);
    import mrfs_pkg::*;

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        mrfs_rx_e              rx_state;
        logic [CFG_WIDTH-1:0]  cfg;
        logic [5:0]            status;
        logic [47:0]           station;
        logic [7:0]            tx_page;
        logic [15:0]           tx_len;
        logic [7:0]            ring_first;
        logic [7:0]            ring_last;
        logic [7:0]            ring_bound;
        logic [7:0]            ring_cur;
        logic [7:0]            link_page;
        logic                  ring_full;
        logic [7:0]            align_tally;
        logic [7:0]            crc_tally;
        logic [7:0]            miss_tally;
        logic [31:0]           rdata;
        logic                  abort_p;
        logic                  commit_p;
        logic                  status_wr_p;
        logic [7:0]            status_out;
        logic                  dma_abort_p;
    } mrfs_state_s;

    mrfs_state_s state_reg;
    mrfs_state_s state_next;

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    // Next page in the ring, wrapping to the first page when the step would reach the last
    function automatic logic [7:0] ring_step(input logic [7:0] page,
                                             input logic [7:0] first,
                                             input logic [7:0] last);
        logic [7:0] nxt;
        nxt = page + 8'h01;
        if (nxt == last) begin
            nxt = first;
        end
        return nxt;
    endfunction : ring_step

    // Saturating tally increment
    function automatic logic [7:0] tally_inc(input logic [7:0] v);
        return (v == TALLY_MAX) ? v : v + 8'h01;
    endfunction : tally_inc

    // --------------------------------------------------------------
    // APB decode
    // --------------------------------------------------------------
    logic       apb_setup;
    logic       apb_access;
    logic [7:0] apb_ofs;
    logic       apb_mapped;
    logic       apb_wr;
    logic       apb_rd;

    assign apb_setup  = apb_req.psel && !apb_req.penable;
    assign apb_access = apb_req.psel && apb_req.penable;
    assign apb_ofs    = apb_req.paddr[7:0];
    assign apb_mapped = (apb_req.paddr[11:8] == 4'h0) && (apb_ofs[1:0] == 2'b00) &&
                        (apb_ofs == OFS_RX_CFG ||
                         (apb_ofs >= OFS_STATION0 && apb_ofs <= OFS_STATION5) ||
                         (apb_ofs >= OFS_TX_PAGE && apb_ofs <= OFS_RING_CUR) ||
                         (apb_ofs >= OFS_ALIGN_TALLY && apb_ofs <= OFS_MISS_TALLY));
    assign apb_wr     = apb_access && apb_req.pwrite && apb_mapped && apb_req.pstrb[0];
    assign apb_rd     = apb_access && !apb_req.pwrite && apb_mapped;

    // --------------------------------------------------------------
    // Packet evaluation at end of frame
    // --------------------------------------------------------------
    logic ev_end;
    logic ev_bcast;
    logic ev_group;
    logic ev_phys_ok;
    logic ev_group_ok;
    logic ev_recog;
    logic ev_size_ok;
    logic ev_crc_err;
    logic ev_align;
    logic ev_err_ok;
    logic ev_missed;
    logic ev_keep;
    logic rx_defer;

    assign ev_end      = rx_end && (state_reg.rx_state == RX_FRAME);
    assign ev_bcast    = rx_frame.dest_addr == ALL_ONES_DEST;
    assign ev_group    = rx_frame.dest_addr[GROUP_BIT];
    assign ev_phys_ok  = !ev_group && (state_reg.cfg[CFG_ANY_PHYS] ||
                         rx_frame.dest_addr == state_reg.station);
    assign ev_group_ok = (ev_bcast && state_reg.cfg[CFG_ALL_ONES]) ||
                         (ev_group && !ev_bcast && state_reg.cfg[CFG_GROUP] &&
                          rx_frame.hash_hit);
    assign ev_recog    = ev_phys_ok || ev_group_ok;
    assign ev_size_ok  = (rx_frame.byte_count >= MIN_FRAME_LEN) ||
                         (state_reg.cfg[CFG_SHORT] &&
                          rx_frame.byte_count >= MIN_RUNT_LEN);
    assign ev_crc_err  = !rx_frame.crc_ok;
    assign ev_align    = ev_crc_err && (rx_frame.dribble_bits != 3'b000);
    assign ev_err_ok   = !ev_crc_err || state_reg.cfg[CFG_SAVE_ERR];
    assign ev_missed   = ev_recog && ev_size_ok &&
                         (state_reg.cfg[CFG_MONITOR] || state_reg.ring_full);
    assign ev_keep     = ev_recog && ev_size_ok && ev_err_ok && !ev_missed;
    assign rx_defer    = carrier_sense || collision;

    // --------------------------------------------------------------
    // Next-state logic
    // --------------------------------------------------------------
    always_comb begin
        logic [7:0] rd;
        logic [7:0] nxt_page;
        logic [7:0] st_byte;
        rd       = 8'h00;
        nxt_page = ring_step(state_reg.link_page, state_reg.ring_first, state_reg.ring_last);
        st_byte  = 8'h00;
        state_next             = state_reg;
        state_next.abort_p     = 1'b0;
        state_next.commit_p    = 1'b0;
        state_next.status_wr_p = 1'b0;
        state_next.dma_abort_p = 1'b0;

        // Read data captured in the setup phase; the offset shares write and read
        unique case (apb_ofs)
            OFS_RX_CFG:      rd = {rx_defer, state_reg.cfg[CFG_MONITOR],
                                   state_reg.status};
            OFS_TX_PAGE:     rd = state_reg.tx_page;
            OFS_TX_LEN_LO:   rd = state_reg.tx_len[7:0];
            OFS_TX_LEN_HI:   rd = state_reg.tx_len[15:8];
            OFS_RING_FIRST:  rd = state_reg.ring_first;
            OFS_RING_LAST:   rd = state_reg.ring_last;
            OFS_RING_BOUND:  rd = state_reg.ring_bound;
            OFS_RING_CUR:    rd = state_reg.ring_cur;
            OFS_ALIGN_TALLY: rd = state_reg.align_tally;
            OFS_CRC_TALLY:   rd = state_reg.crc_tally;
            OFS_MISS_TALLY:  rd = state_reg.miss_tally;
            default: begin
                if (apb_ofs >= OFS_STATION0 && apb_ofs <= OFS_STATION5) begin
                    rd = state_reg.station[8*(5-int'(apb_ofs[4:2])) +: 8];
                end
            end
        endcase
        if (apb_setup) begin
            state_next.rdata = apb_mapped ? {24'h000000, rd} : 32'h0000_0000;
        end

        // Register writes, eight bits each except six for the receive configuration
        if (apb_wr) begin
            unique case (apb_ofs)
                OFS_RX_CFG:     state_next.cfg        = apb_req.pwdata[CFG_WIDTH-1:0];
                OFS_TX_PAGE:    state_next.tx_page    = apb_req.pwdata[7:0];
                OFS_TX_LEN_LO:  state_next.tx_len[7:0]  = apb_req.pwdata[7:0];
                OFS_TX_LEN_HI:  state_next.tx_len[15:8] = apb_req.pwdata[7:0];
                OFS_RING_FIRST: state_next.ring_first = apb_req.pwdata[7:0];
                OFS_RING_LAST:  state_next.ring_last  = apb_req.pwdata[7:0];
                OFS_RING_BOUND: state_next.ring_bound = apb_req.pwdata[7:0];
                OFS_RING_CUR:   state_next.ring_cur   = apb_req.pwdata[7:0];
                default: begin
                    if (apb_ofs >= OFS_STATION0 && apb_ofs <= OFS_STATION5) begin
                        state_next.station[8*(5-int'(apb_ofs[4:2])) +: 8] =
                            apb_req.pwdata[7:0];
                    end
                end
            endcase
        end

        // Tallies clear on read; a same-cycle increment below still lands
        if (apb_rd) begin
            if (apb_ofs == OFS_ALIGN_TALLY) state_next.align_tally = 8'h00;
            if (apb_ofs == OFS_CRC_TALLY)   state_next.crc_tally   = 8'h00;
            if (apb_ofs == OFS_MISS_TALLY)  state_next.miss_tally  = 8'h00;
        end

        // Receive sequence
        unique case (state_reg.rx_state)
            RX_IDLE: begin
                if (rx_start) begin
                    state_next.status    = 6'b000000;
                    state_next.ring_full = 1'b0;
                    state_next.link_page = state_reg.ring_cur;
                    state_next.rx_state  = RX_FRAME;
                end
            end
            RX_FRAME: begin
                if (rx_fifo_overflow) begin
                    state_next.status[ST_FIFO_OVF] = 1'b1;
                    state_next.abort_p  = 1'b1;
                    state_next.rx_state = RX_DROP;
                end else if (rx_end) begin
                    st_byte[ST_CRC]       = ev_crc_err || ev_align;
                    st_byte[ST_ALIGN]     = ev_align;
                    st_byte[ST_MISSED]    = ev_missed;
                    st_byte[ST_ADDR_TYPE] = ev_group;
                    st_byte[ST_INTACT]    = !ev_crc_err && !ev_align && !ev_missed;
                    st_byte[ST_RX_DIS]    = state_reg.cfg[CFG_MONITOR];
                    st_byte[ST_DEFER]     = rx_defer;
                    state_next.status     = st_byte[5:0];
                    if (ev_recog && ev_crc_err) begin
                        state_next.crc_tally = tally_inc(state_next.crc_tally);
                    end
                    if (ev_recog && ev_align) begin
                        state_next.align_tally = tally_inc(state_next.align_tally);
                    end
                    if (ev_missed) begin
                        state_next.miss_tally = tally_inc(state_next.miss_tally);
                    end
                    if (ev_keep) begin
                        state_next.status_wr_p = 1'b1;
                        state_next.status_out  = st_byte;
                        state_next.commit_p    = 1'b1;
                        state_next.ring_cur    = nxt_page;
                    end
                    state_next.rx_state = RX_IDLE;
                end else if (rx_link_req && !state_reg.ring_full &&
                             !state_reg.cfg[CFG_MONITOR]) begin
                    if (nxt_page == state_reg.ring_bound) begin
                        state_next.dma_abort_p = 1'b1;
                        state_next.ring_full   = 1'b1;
                    end else begin
                        state_next.link_page = nxt_page;
                    end
                end
            end
            RX_DROP: begin
                if (rx_end) begin
                    state_next.rx_state = RX_IDLE;
                end
            end
        endcase
    end

    // --------------------------------------------------------------
    // State register
    // --------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg          <= '0;
            state_reg.rx_state <= RX_IDLE;
            state_reg.cfg      <= CFG_RESET[CFG_WIDTH-1:0];
        end else begin
            state_reg <= state_next;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign prdata      = state_reg.rdata;
    assign pready      = 1'b1;                                   // Zero wait states
    assign pslverr     = apb_access && !apb_mapped;
    assign rx_abort    = state_reg.abort_p;
    assign rx_commit   = state_reg.commit_p;
    assign status_wr   = state_reg.status_wr_p;
    assign status_byte = state_reg.status_out;
    assign dma_abort   = state_reg.dma_abort_p;
    assign rx_dma_addr = {state_reg.link_page, PAGE_LOW_ZERO};
    assign tx_dma_addr = {state_reg.tx_page, PAGE_LOW_ZERO};
    assign tx_length   = state_reg.tx_len;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence seq_overflow;
        state_reg.rx_state == RX_FRAME && rx_fifo_overflow;
    endsequence

    sequence seq_aborted;
        rx_abort && state_reg.status[ST_FIFO_OVF] ##1 !rx_abort;
    endsequence

    a_errored_dropped: assert property (ev_end && !rx_fifo_overflow && ev_crc_err &&
        !state_reg.cfg[CFG_SAVE_ERR] |=> !status_wr)
        else $error("errored packet stored with save bit clear");

    a_runt_limit: assert property (ev_end && !rx_fifo_overflow &&
        rx_frame.byte_count < MIN_RUNT_LEN |=> !status_wr && !rx_commit)
        else $error("packet under eight bytes accepted");

    a_bcast_gate: assert property (ev_end && !rx_fifo_overflow && ev_bcast &&
        !state_reg.cfg[CFG_ALL_ONES] |=> !status_wr)
        else $error("broadcast accepted with bit clear");

    a_monitor_nobuf: assert property (ev_end && state_reg.cfg[CFG_MONITOR] |=>
        !status_wr && !rx_commit)
        else $error("packet buffered in monitor mode");

    a_intact_bit: assert property (status_wr |->
        status_byte[ST_INTACT] == (status_byte[ST_MISSED:ST_CRC] == 4'h0))
        else $error("intact bit disagrees with error bits");

    a_align_coding: assert property (status_wr |->
        !(status_byte[ST_ALIGN] && !status_byte[ST_CRC]))
        else $error("alignment error without CRC error");

    a_status_clear: assert property (state_reg.rx_state == RX_IDLE && rx_start |=>
        state_reg.status == 6'b000000 && state_reg.rx_state == RX_FRAME)
        else $error("status not cleared on packet arrival");

    a_overflow_abort: assert property (seq_overflow |=> seq_aborted)
        else $error("overflow did not abort the packet");

    a_missed_tally: assert property (ev_end && !rx_fifo_overflow && ev_missed &&
        state_reg.miss_tally != TALLY_MAX && !(apb_rd && apb_ofs == OFS_MISS_TALLY) |=>
        state_reg.miss_tally == $past(state_reg.miss_tally) + 8'h01)
        else $error("missed tally not incremented");

    a_ring_abort: assert property (state_reg.rx_state == RX_FRAME && !rx_end &&
        !rx_fifo_overflow && rx_link_req && !state_reg.ring_full &&
        !state_reg.cfg[CFG_MONITOR] && ring_step(state_reg.link_page,
        state_reg.ring_first, state_reg.ring_last) == state_reg.ring_bound |=>
        dma_abort && $stable(rx_dma_addr) ##1 !dma_abort)
        else $error("boundary hit did not abort local DMA");

endmodule : mrfs_core

// ==== test/mrfs_rx_model.sv ====
// Frame source standing in for the serial interface side
`timescale 1ns/100ps
module mrfs_rx_model (
    input  wire logic            clock,
    output mrfs_pkg::mrfs_frame_s rx_frame,
    output logic                 rx_start,
    output logic                 rx_end,
    output logic                 rx_fifo_overflow,
    output logic                 rx_link_req
);
    import mrfs_pkg::*;
    // Idle lines, no page linking requested
    initial begin
        rx_frame = '0;
        {rx_start, rx_end, rx_fifo_overflow, rx_link_req} = 4'h0;
    end
    // Start pulse, page link pulses, optional overflow, then end pulse with descriptor
    task automatic send(input mrfs_frame_s f, input int links = 0, input logic ovf = 1'b0);
        @(posedge clock) rx_start <= 1'b1;
        @(posedge clock) rx_start <= 1'b0;
        for (int i = 0; i < links; i++) begin
            @(posedge clock) rx_link_req <= 1'b1;
            @(posedge clock) rx_link_req <= 1'b0;
        end
        @(posedge clock) rx_fifo_overflow <= ovf;
        @(posedge clock) begin
            rx_fifo_overflow <= 1'b0;
            rx_end <= 1'b1;
            rx_frame <= f;
        end
        @(posedge clock) begin
            rx_end <= 1'b0;
            rx_frame <= ~f; // Descriptor stale, show garbage
        end
    endtask : send
endmodule : mrfs_rx_model

// ==== test/tb_top.sv ====
// Bench: filter, status and tallies via APB and a frame source
`timescale 1ns/100ps
module tb_top;
    import mrfs_pkg::*;
    localparam logic [47:0] STA = 48'h021122334455;
    localparam logic [47:0] GRP = 48'h01005e000001;
    logic          clock = 1'b0;
    logic          sys_rst = 1'b1;
    logic          carrier = 1'b0;
    logic          col = 1'b0;
    logic [15:0]   rxa, txa, txl;
    logic          abt, cmt, dab;
    int            n_abt = 0;
    int            n_dab = 0;
    mrfs_apb_req_s apb_req = '0;
    mrfs_frame_s   frame;
    logic [31:0]   prdata, rd;
    logic [7:0]    sbyte;
    logic          pready, pslverr, st, se, ovf, link, swr, err;
    int            n_errors = 0;
    int            n_checks = 0;
    always #5 clock = ~clock;
    // Partner and device
    mrfs_rx_model mrfs_rx_model_i (.clock(clock), .rx_frame(frame), .rx_start(st),
        .rx_end(se), .rx_fifo_overflow(ovf), .rx_link_req(link));
    mrfs_core mrfs_core_i (.clock(clock), .sys_rst(sys_rst), .apb_req(apb_req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_start(st), .rx_end(se),
        .rx_frame(frame), .rx_fifo_overflow(ovf), .rx_link_req(link),
        .carrier_sense(carrier), .collision(col), .rx_abort(abt), .rx_commit(cmt),
        .status_wr(swr), .status_byte(sbyte), .dma_abort(dab), .rx_dma_addr(rxa),
        .tx_dma_addr(txa), .tx_length(txl));
    // Count one-cycle abort pulses from the device
    always @(posedge clock) begin
        if (abt === 1'b1) n_abt <= n_abt + 1;
        if (dab === 1'b1) n_dab <= n_dab + 1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    // One APB transfer, byte wide, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge clock) apb_req <= '{1'b1, 1'b0, w, {4'h0, a}, {24'h0, d}, 4'hf};
        @(posedge clock) apb_req.penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            n_errors++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        apb_req <= '0;
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rd, {24'h0, e});
    endtask : rdc
    // Send a frame, then look for the status write pulse
    task automatic rx(input logic [47:0] da, input logic [15:0] n, input logic [3:0] e,
                      input logic ew, input logic [7:0] eb, input int lk = 0,
                      input logic ov = 1'b0, input logic hh = 1'b1);
        logic seen;
        seen = 1'b0;
        mrfs_rx_model_i.send('{da, n, e[3], e[2:0], hh}, lk, ov);
        repeat (3) begin
            #1;
            if (swr === 1'b1) begin
                seen = 1'b1;
                chk(sbyte, eb);
                chk(cmt, 1'b1);
            end
            @(posedge clock);
        end
        chk(seen, ew);
    endtask : rx
    task automatic sc_filter();
        apb(1'b1, OFS_RX_CFG, 8'h00);
        rx(STA, 16'd64, 4'h8, 1'b1, 8'h01);
        rx(~STA & 48'hfeffffffffff, 16'd64, 4'h8, 1'b0, 8'h00);
        rx(ALL_ONES_DEST, 16'd64, 4'h8, 1'b0, 8'h00);
        rx(GRP, 16'd64, 4'h8, 1'b0, 8'h00);
        apb(1'b1, OFS_RX_CFG, 8'h1c);
        rx(16'd99, 16'd64, 4'h8, 1'b1, 8'h01);
        rx(ALL_ONES_DEST, 16'd64, 4'h8, 1'b1, 8'h21);
        rx(GRP, 16'd64, 4'h8, 1'b1, 8'h21);
        rx(GRP, 16'd64, 4'h8, 1'b0, 8'h00, 0, 1'b0, 1'b0);
    endtask : sc_filter
    task automatic sc_errors();
        apb(1'b1, OFS_RX_CFG, 8'h00);
        rx(STA, 16'd64, 4'h0, 1'b0, 8'h00);
        apb(1'b1, OFS_RX_CFG, 8'h01);
        rx(STA, 16'd64, 4'h0, 1'b1, 8'h02);
        rx(STA, 16'd64, 4'h3, 1'b1, 8'h06);
        rx(STA, 16'd64, 4'hd, 1'b1, 8'h01);
        rdc(OFS_CRC_TALLY, 8'h03);
        rdc(OFS_ALIGN_TALLY, 8'h01);
        rx(STA, 16'd63, 4'h8, 1'b0, 8'h00);
        apb(1'b1, OFS_RX_CFG, 8'h02);
        rx(STA, 16'd8, 4'h8, 1'b1, 8'h01);
        rx(STA, 16'd7, 4'h8, 1'b0, 8'h00);
    endtask : sc_errors
    task automatic sc_monitor();
        apb(1'b1, OFS_RX_CFG, 8'h20);
        carrier <= 1'b1;
        rx(STA, 16'd64, 4'h8, 1'b0, 8'h00);
        rdc(OFS_RX_CFG, 8'hd0);
        rdc(OFS_MISS_TALLY, 8'h01);
        apb(1'b1, OFS_RX_CFG, 8'h00);
        carrier <= 1'b0;
        rdc(OFS_RX_CFG, 8'h10);
        rx(STA, 16'd64, 4'h8, 1'b1, 8'h01);
        rdc(OFS_RX_CFG, 8'h01);
        col <= 1'b1;
        rdc(OFS_RX_CFG, 8'h81);
        col <= 1'b0;
    endtask : sc_monitor
    task automatic sc_ring();
        apb(1'b1, OFS_TX_PAGE, 8'h3a);
        apb(1'b1, OFS_TX_LEN_LO, 8'hee);
        apb(1'b1, OFS_TX_LEN_HI, 8'h05);
        rdc(OFS_TX_LEN_LO, 8'hee);
        chk(txa, 32'h3a00);
        chk(txl, 32'h05ee);
        apb(1'b1, OFS_RING_FIRST, 8'h10);
        apb(1'b1, OFS_RING_LAST, 8'h14);
        apb(1'b1, OFS_RING_BOUND, 8'h13);
        apb(1'b1, OFS_RING_CUR, 8'h10);
        rx(STA, 16'd64, 4'h8, 1'b1, 8'h01, 1);
        rdc(OFS_RING_CUR, 8'h12);
        chk(rxa, 32'h1100);
        rx(STA, 16'd64, 4'h8, 1'b0, 8'h00, 1);
        chk(n_dab, 1);
        chk(rxa, 32'h1200);
        rdc(OFS_RX_CFG, 8'h10);
        rdc(OFS_MISS_TALLY, 8'h01);
        rx(STA, 16'd64, 4'h8, 1'b0, 8'h00, 0, 1'b1);
        chk(n_abt, 1);
        rdc(OFS_RX_CFG, 8'h08);
    endtask : sc_ring
    // Main sequence
    initial begin
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        rdc(OFS_ALIGN_TALLY, 8'h00);
        apb(1'b0, 8'hfc, 8'h00);
        chk(err, 1'b1);
        for (int i = 0; i < 6; i++) apb(1'b1, OFS_STATION0 + 8'(4 * i), STA[47 - 8 * i -: 8]);
        sc_filter();
        sc_errors();
        sc_monitor();
        sc_ring();
        summarize();
    end
endmodule : tb_top
